// file: inc/pwa_pkg.sv
package pwa_pkg;
	// ----------------------------------------
	// bus and register indices
	// ----------------------------------------
	localparam int ADDR_W = 20;
	localparam int NSLOT = 21;
	localparam logic [17:0] IDX_MAX_PER = 18'h0fe1b;
	localparam logic [17:0] IDX_LL_FREQ = 18'h0fe1c;
	localparam logic [17:0] IDX_DITHER = 18'h0fe1d;
	localparam logic [17:0] IDX_DIVIDER = 18'h0fe1e;
	localparam logic [17:0] IDX_LL_THR = 18'h0fe32;
	localparam logic [17:0] IDX_PWR_LOW = 18'h0fe44;
	localparam logic [17:0] IDX_PWR_HIGH = 18'h0fe45;
	localparam logic [17:0] IDX_LOWV_1 = 18'h0fe46;
	localparam logic [17:0] IDX_LOWV_2 = 18'h0fe47;
	localparam logic [17:0] IDX_HIGHV_1 = 18'h0fe48;
	localparam logic [17:0] IDX_HIGHV_2 = 18'h0fe49;
	localparam logic [17:0] IDX_SUPERV = 18'h0fe4a;
	localparam logic [17:0] IDX_DELAY = 18'h0fe4c;
	localparam logic [17:0] IDX_SUPER_HYS = 18'h0fe4d;
	localparam logic [17:0] IDX_LL_HYS = 18'h0fe4e;
	localparam logic [17:0] IDX_ENABLE = 18'h0fe4f;
	localparam logic [17:0] IDX_NOM_PER = 18'h0fe60;
	localparam logic [17:0] IDX_VOUT_NOM = 18'h0fe61;
	localparam logic [17:0] IDX_LOW_THR = 18'h0fe62;
	localparam logic [17:0] IDX_HIGH_THR = 18'h0fe63;
	localparam logic [17:0] IDX_SUPER_THR = 18'h0fe64;
	localparam logic [17:0] IDX_STATUS = 18'h0fe65;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_NOM_PER = 8'h64;
	localparam logic [7:0] RST_MAX_PER = 8'h78;
	localparam logic [7:0] RST_LL_FREQ = 8'h96;
	localparam logic [7:0] RST_VOUT_NOM = 8'hc8;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// ----------------------------------------
	// enable bit positions
	// ----------------------------------------
	localparam int EN_DITHER = 0;
	localparam int EN_SYNC = 1;
	localparam int EN_SETPOINT = 2;
	localparam int EN_LL_FREQ = 3;
	localparam int EN_SHED = 4;
	localparam int EN_LL_FILTER = 5;
	localparam int EN_FEEDFWD = 6;
	// ----------------------------------------
	// timing constants
	// ----------------------------------------
	localparam int PER_SHIFT = 2;
	localparam int SYNC_AVG_CNT = 7;
	localparam logic [2:0] FILTER_LINE_CYCLES = 3'h4;
	localparam int PHASE_TOL = 2;
	// ----------------------------------------
	// lock states
	// ----------------------------------------
	typedef enum logic [2:0] {S_FREE, S_FCAP, S_PCAP, S_LOCK, S_FALLBACK} pwa_lock_e;
endpackage : pwa_pkg

// file: rtl/pwa_interp.sv
`timescale 1ns/100ps
module pwa_interp #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// power and load line points
	input wire logic [W-1:0] pwr,
	input wire logic [W-1:0] p_lo,
	input wire logic [W-1:0] p_hi,
	input wire logic [W-1:0] v_lo,
	input wire logic [W-1:0] v_hi,
	// result
	output logic [W-1:0] v_out
);
	// ----------------------------------------
	// linear segment with clamped ends
	// ----------------------------------------
	logic [W-1:0] v_r;
	logic [W-1:0] v_nxt;
	wire below = (pwr <= p_lo) || (p_hi <= p_lo);
	wire above = pwr >= p_hi;
	wire [W-1:0] dp = pwr - p_lo;
	wire [W-1:0] span = p_hi - p_lo;
	wire rising = v_hi >= v_lo;
	wire [W-1:0] dv = rising ? (v_hi - v_lo) : (v_lo - v_hi);
	wire [2*W-1:0] prod = dv * dp;
	wire [2*W-1:0] quo = prod / {{W{1'b0}}, (span == '0) ? {{(W-1){1'b0}}, 1'b1} : span};
	wire [W-1:0] step = quo[W-1:0];
	assign v_nxt = below ? v_lo : above ? v_hi : rising ? (v_lo + step) : (v_lo - step);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) v_r <= '0;
		else v_r <= v_nxt;
	end
	assign v_out = v_r;
endmodule : pwa_interp

// file: rtl/pwa_top.sv
`timescale 1ns/100ps
module pwa_top #(
	parameter int PER_W = 12
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	// avalon-mm slave
	input wire logic [pwa_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// measurements and system state
	input wire logic SOFT_START,
	input wire logic LINE_CYCLE,
	input wire logic [7:0] VRMS_AVG,
	input wire logic [7:0] PIN_AVG,
	input wire logic [7:0] VLINE_RECT,
	// external timing input
	input wire logic SYNC_IN,
	// pwm timing outputs
	output logic PWM_CYCLE_START,
	output logic [PER_W-1:0] SW_PERIOD,
	output logic SYNC_LOCKED,
	// loop controls
	output logic [7:0] VOUT_SETPOINT,
	output logic LL_FREQ_ACTIVE,
	output logic LL_FILTER_SEL,
	output logic FEEDFWD_EN,
	output logic SECOND_PWM_ENABLE,
	// bridgeless drive
	input wire logic BRIDGELESS_EN,
	input wire logic PWM_DRIVE,
	input wire logic LINE_PHASE_SENSE_INPUT,
	input wire logic LINE_PHASE_OK,
	output logic FIRST_BOOST_TRANSISTOR,
	output logic SECOND_BOOST_TRANSISTOR
);
	// ----------------------------------------
	// register slot decode
	// ----------------------------------------
	function automatic logic [5:0] slot_of(input logic [17:0] idx);
		logic [5:0] s;
		s = 6'h3f;
		if (idx == pwa_pkg::IDX_MAX_PER) s = 6'h00;
		else if (idx == pwa_pkg::IDX_LL_FREQ) s = 6'h01;
		else if (idx == pwa_pkg::IDX_DITHER) s = 6'h02;
		else if (idx == pwa_pkg::IDX_DIVIDER) s = 6'h03;
		else if (idx == pwa_pkg::IDX_LL_THR) s = 6'h04;
		else if (idx == pwa_pkg::IDX_PWR_LOW) s = 6'h05;
		else if (idx == pwa_pkg::IDX_PWR_HIGH) s = 6'h06;
		else if (idx == pwa_pkg::IDX_LOWV_1) s = 6'h07;
		else if (idx == pwa_pkg::IDX_LOWV_2) s = 6'h08;
		else if (idx == pwa_pkg::IDX_HIGHV_1) s = 6'h09;
		else if (idx == pwa_pkg::IDX_HIGHV_2) s = 6'h0a;
		else if (idx == pwa_pkg::IDX_SUPERV) s = 6'h0b;
		else if (idx == pwa_pkg::IDX_DELAY) s = 6'h0c;
		else if (idx == pwa_pkg::IDX_SUPER_HYS) s = 6'h0d;
		else if (idx == pwa_pkg::IDX_LL_HYS) s = 6'h0e;
		else if (idx == pwa_pkg::IDX_ENABLE) s = 6'h0f;
		else if (idx == pwa_pkg::IDX_NOM_PER) s = 6'h10;
		else if (idx == pwa_pkg::IDX_VOUT_NOM) s = 6'h11;
		else if (idx == pwa_pkg::IDX_LOW_THR) s = 6'h12;
		else if (idx == pwa_pkg::IDX_HIGH_THR) s = 6'h13;
		else if (idx == pwa_pkg::IDX_SUPER_THR) s = 6'h14;
		return s;
	endfunction : slot_of

	function automatic logic [7:0] rst_of(input int s);
		logic [7:0] v;
		v = pwa_pkg::RST_ZERO;
		if (s == 0) v = pwa_pkg::RST_MAX_PER;
		else if (s == 1) v = pwa_pkg::RST_LL_FREQ;
		else if (s == 16) v = pwa_pkg::RST_NOM_PER;
		else if (s == 17) v = pwa_pkg::RST_VOUT_NOM;
		return v;
	endfunction : rst_of

	function automatic logic [PER_W-1:0] to_per(input logic [7:0] r);
		return PER_W'({r, {pwa_pkg::PER_SHIFT{1'b0}}});
	endfunction : to_per

	// ----------------------------------------
	// avalon slave
	// ----------------------------------------
	logic [7:0] regs_r [pwa_pkg::NSLOT];
	logic ack_r;
	logic [31:0] rdata_r;
	logic [7:0] status_w;
	wire req = AVS_READ | AVS_WRITE;
	wire [17:0] bus_idx = AVS_ADDRESS[pwa_pkg::ADDR_W-1:2];
	wire aligned = AVS_ADDRESS[1:0] == 2'h0;
	wire [5:0] bus_slot = slot_of(bus_idx);
	wire slot_hit = aligned && (bus_slot != 6'h3f);
	wire stat_hit = aligned && (bus_idx == pwa_pkg::IDX_STATUS);
	wire wr_fire = AVS_WRITE && ack_r && slot_hit && AVS_BYTEENABLE[0];
	wire [31:0] rd_val = slot_hit ? {24'h0, regs_r[bus_slot[4:0]]} :
		stat_hit ? {24'h0, status_w} : 32'h0;
	assign AVS_WAITREQUEST = req & ~ack_r;
	assign AVS_READDATA = rdata_r;

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			ack_r <= req & ~ack_r;
			if (AVS_READ && !ack_r) rdata_r <= rd_val;
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			for (int i = 0; i < pwa_pkg::NSLOT; i++) regs_r[i] <= rst_of(i);
		end else if (wr_fire) begin
			regs_r[bus_slot[4:0]] <= AVS_WRITEDATA[7:0];
		end
	end

	// ----------------------------------------
	// register fields
	// ----------------------------------------
	wire [7:0] en = regs_r[15];
	wire en_dither = en[pwa_pkg::EN_DITHER];
	wire en_sync = en[pwa_pkg::EN_SYNC];
	wire en_setp = en[pwa_pkg::EN_SETPOINT];
	wire en_llf = en[pwa_pkg::EN_LL_FREQ];
	wire en_shed = en[pwa_pkg::EN_SHED];
	wire en_filt = en[pwa_pkg::EN_LL_FILTER];
	wire [PER_W-1:0] nom_per = to_per(regs_r[16]);
	wire [PER_W-1:0] max_per = to_per(regs_r[0]);
	wire [PER_W-1:0] ll_per = to_per(regs_r[1]);
	wire [PER_W-1:0] dly = to_per(regs_r[12]);
	wire [1:0] divider = regs_r[3][1:0];
	assign FEEDFWD_EN = en[pwa_pkg::EN_FEEDFWD];

	// ----------------------------------------
	// light-load decisions per line cycle
	// ----------------------------------------
	logic light_r;
	logic [2:0] filt_cnt_r;
	logic filt_r;
	logic shl_r;
	wire [8:0] ll_up = {1'b0, regs_r[4]} + {1'b0, regs_r[14]};
	wire go_light = PIN_AVG < regs_r[4];
	wire go_heavy = {1'b0, PIN_AVG} > ll_up;
	wire [8:0] shl_lo = {1'b0, regs_r[20]} - {1'b0, regs_r[13]};

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			light_r <= 1'b0;
			shl_r <= 1'b0;
		end else if (LINE_CYCLE) begin
			if (go_light) light_r <= 1'b1;
			else if (go_heavy) light_r <= 1'b0;
			if (VRMS_AVG > regs_r[20]) shl_r <= 1'b1;
			else if ({1'b0, VRMS_AVG} < shl_lo || regs_r[13] > regs_r[20]) shl_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			filt_cnt_r <= 3'h0;
			filt_r <= 1'b0;
		end else if (!en_filt || (LINE_CYCLE && go_heavy)) begin
			filt_cnt_r <= 3'h0;
			filt_r <= 1'b0;
		end else if (LINE_CYCLE && light_r && !filt_r) begin
			filt_cnt_r <= filt_cnt_r + 3'h1;
			filt_r <= (filt_cnt_r + 3'h1) == pwa_pkg::FILTER_LINE_CYCLES;
		end
	end
	assign LL_FILTER_SEL = filt_r;
	assign LL_FREQ_ACTIVE = en_llf & light_r;
	assign SECOND_PWM_ENABLE = ~(en_shed & light_r);

	// ----------------------------------------
	// smart output voltage
	// ----------------------------------------
	logic [7:0] vsp_r;
	logic [7:0] interp_v;
	wire high_line = VRMS_AVG > regs_r[19];
	wire low_line = VRMS_AVG < regs_r[18];
	wire [7:0] seg_v1 = high_line ? regs_r[9] : regs_r[7];
	wire [7:0] seg_v2 = high_line ? regs_r[10] : regs_r[8];
	pwa_interp #(.W(8)) u_interp (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.pwr(PIN_AVG),
		.p_lo(regs_r[5]),
		.p_hi(regs_r[6]),
		.v_lo(seg_v1),
		.v_hi(seg_v2),
		.v_out(interp_v)
	);
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) vsp_r <= pwa_pkg::RST_VOUT_NOM;
		else if (!en_setp) vsp_r <= regs_r[17];
		else if (shl_r) vsp_r <= regs_r[11];
		else if (high_line || low_line) vsp_r <= interp_v;
	end
	assign VOUT_SETPOINT = vsp_r;

	// ----------------------------------------
	// external timing capture
	// ----------------------------------------
	pwa_pkg::pwa_lock_e st_r;
	logic sync_d_r;
	logic [1:0] div_cnt_r;
	logic [PER_W-1:0] since_r;
	logic [PER_W+2:0] sum_r;
	logic [2:0] n_r;
	logic seen_r;
	logic [PER_W-1:0] lock_per_r;
	logic [PER_W-1:0] cnt_r;
	wire rise = SYNC_IN & ~sync_d_r;
	wire dsync = rise && (div_cnt_r == divider);
	wire [PER_W-1:0] win_lo = nom_per - (nom_per >> 3);
	wire [PER_W-1:0] win_hi = nom_per + (nom_per >> 3);
	wire [PER_W-1:0] meas = since_r + 1'b1;
	wire in_win = (meas >= win_lo) && (meas <= win_hi) && (meas <= max_per);
	wire lost = since_r > (win_hi + (win_hi >> 1));
	wire sync_on = en_sync && !SOFT_START;
	wire [PER_W+2:0] sum_nxt = sum_r + (PER_W+3)'(meas);
	wire [PER_W-1:0] avg = PER_W'(sum_nxt / (PER_W+3)'(pwa_pkg::SYNC_AVG_CNT));
	wire [PER_W-1:0] tgt = (lock_per_r > dly) ? (lock_per_r - dly) : '0;
	wire [PER_W-1:0] perr = (cnt_r > tgt) ? (cnt_r - tgt) : (tgt - cnt_r);
	wire aligned_ph = perr <= PER_W'(pwa_pkg::PHASE_TOL);

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			sync_d_r <= 1'b0;
			div_cnt_r <= 2'h0;
			since_r <= '0;
		end else begin
			sync_d_r <= SYNC_IN;
			if (rise) div_cnt_r <= (div_cnt_r == divider) ? 2'h0 : div_cnt_r + 2'h1;
			if (dsync || !sync_on) since_r <= '0;
			else if (since_r != '1) since_r <= since_r + 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_r <= pwa_pkg::S_FREE;
			sum_r <= '0;
			n_r <= 3'h0;
			seen_r <= 1'b0;
			lock_per_r <= '0;
		end else if (!sync_on) begin
			st_r <= pwa_pkg::S_FREE;
			seen_r <= 1'b0;
		end else begin
			case (st_r)
				pwa_pkg::S_FREE, pwa_pkg::S_FALLBACK: begin
					if (dsync) begin
						st_r <= pwa_pkg::S_FCAP;
						sum_r <= '0;
						n_r <= 3'h0;
						seen_r <= 1'b1;
					end
				end
				pwa_pkg::S_FCAP: begin
					if (lost || (dsync && seen_r && !in_win)) begin
						st_r <= pwa_pkg::S_FALLBACK;
					end else if (dsync) begin
						sum_r <= sum_nxt;
						n_r <= n_r + 3'h1;
						if (n_r == 3'(pwa_pkg::SYNC_AVG_CNT - 1)) begin
							lock_per_r <= (avg > max_per) ? max_per : avg;
							st_r <= pwa_pkg::S_PCAP;
						end
					end
				end
				pwa_pkg::S_PCAP: begin
					if (lost || (dsync && !in_win)) st_r <= pwa_pkg::S_FALLBACK;
					else if (dsync && aligned_ph) st_r <= pwa_pkg::S_LOCK;
				end
				pwa_pkg::S_LOCK: begin
					if (lost || (dsync && !in_win)) st_r <= pwa_pkg::S_FALLBACK;
					else if (dsync) lock_per_r <= (meas > max_per) ? max_per : meas;
				end
				default: st_r <= pwa_pkg::S_FREE;
			endcase
		end
	end
	assign SYNC_LOCKED = st_r == pwa_pkg::S_LOCK;

	// ----------------------------------------
	// switching period generation
	// ----------------------------------------
	logic [7:0] mod_r;
	logic [7:0] dith_cnt_r;
	logic start_r;
	logic [PER_W-1:0] per_r;
	logic [PER_W-1:0] per_nxt;
	wire [PER_W-1:0] base = LL_FREQ_ACTIVE ? ll_per : nom_per;
	wire [PER_W+7:0] bprod = base * mod_r;
	wire [PER_W-1:0] dith = base - (base >> 3) + PER_W'(bprod >> 10);
	wire [PER_W-1:0] free_per = en_dither ? dith : base;
	wire sync_per = (st_r == pwa_pkg::S_PCAP) || (st_r == pwa_pkg::S_LOCK);
	assign per_nxt = (sync_on && st_r == pwa_pkg::S_FALLBACK) ? max_per :
		(sync_on && sync_per) ? lock_per_r : free_per;
	wire [PER_W-1:0] run_per = (per_r < PER_W'(2)) ? PER_W'(2) : per_r;
	wire wrap = cnt_r >= run_per - 1'b1;
	wire lock_edge = SYNC_LOCKED && dsync && sync_on;
	wire phase_pull = sync_on && dsync && (st_r == pwa_pkg::S_PCAP) && !aligned_ph;
	wire jump = lock_edge || phase_pull;

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			cnt_r <= '0;
			start_r <= 1'b0;
			per_r <= to_per(pwa_pkg::RST_NOM_PER);
		end else begin
			start_r <= wrap && !jump;
			if (jump) cnt_r <= tgt;
			else if (wrap) cnt_r <= '0;
			else cnt_r <= cnt_r + 1'b1;
			if (wrap) per_r <= per_nxt;
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			mod_r <= 8'h00;
			dith_cnt_r <= 8'h00;
		end else if (wrap) begin
			if (dith_cnt_r >= regs_r[2]) begin
				dith_cnt_r <= 8'h00;
				mod_r <= VLINE_RECT;
			end else begin
				dith_cnt_r <= dith_cnt_r + 8'h01;
			end
		end
	end
	assign PWM_CYCLE_START = start_r;
	assign SW_PERIOD = per_r;
	assign status_w = {3'h0, filt_r, light_r, shl_r, st_r == pwa_pkg::S_FALLBACK, SYNC_LOCKED};

	// ----------------------------------------
	// bridgeless gate drive
	// ----------------------------------------
	wire steer = BRIDGELESS_EN && !SOFT_START && LINE_PHASE_OK;
	wire q1_nxt = steer ? (LINE_PHASE_SENSE_INPUT ? PWM_DRIVE : 1'b1) : PWM_DRIVE;
	wire q2_nxt = steer ? (LINE_PHASE_SENSE_INPUT ? 1'b1 : PWM_DRIVE) : PWM_DRIVE;
	logic q1_r;
	logic q2_r;
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			q1_r <= 1'b0;
			q2_r <= 1'b0;
		end else begin
			q1_r <= q1_nxt;
			q2_r <= q2_nxt;
		end
	end
	assign FIRST_BOOST_TRANSISTOR = q1_r;
	assign SECOND_BOOST_TRANSISTOR = q2_r;
endmodule : pwa_top

// file: verif/pwa_top_assertions.sv
`timescale 1ns/100ps
module pwa_top_chk #(
	parameter int PER_W = 12
) (
	// clock, reset and bus
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic [pwa_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic AVS_WAITREQUEST,
	// system inputs
	input wire logic SOFT_START,
	input wire logic LINE_CYCLE,
	input wire logic BRIDGELESS_EN,
	input wire logic PWM_DRIVE,
	input wire logic LINE_PHASE_SENSE_INPUT,
	input wire logic LINE_PHASE_OK,
	// watched outputs
	input wire logic SYNC_LOCKED,
	input wire logic LL_FREQ_ACTIVE,
	input wire logic LL_FILTER_SEL,
	input wire logic FEEDFWD_EN,
	input wire logic SECOND_PWM_ENABLE,
	input wire logic FIRST_BOOST_TRANSISTOR,
	input wire logic SECOND_BOOST_TRANSISTOR
);
	// ----------------------------------------
	// helpers and properties
	// ----------------------------------------
	wire logic wr_en = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
		&& (AVS_ADDRESS == {pwa_pkg::IDX_ENABLE, 2'b00});
	wire logic ev = LINE_CYCLE || AVS_WRITE;
	wire logic br = BRIDGELESS_EN && LINE_PHASE_OK && !SOFT_START;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	property p_wait; $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endproperty
	a_wait: assert property (p_wait) else $error("bus answer not after one wait cycle");
	property p_idle; !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST; endproperty
	a_idle: assert property (p_idle) else $error("wait request without request");
	property p_ffwd; wr_en |=> FEEDFWD_EN == $past(AVS_WRITEDATA[6]); endproperty
	a_ffwd: assert property (p_ffwd) else $error("feedforward enable wrong");
	property p_pos; br && LINE_PHASE_SENSE_INPUT |=>
		FIRST_BOOST_TRANSISTOR == $past(PWM_DRIVE) && SECOND_BOOST_TRANSISTOR; endproperty
	a_pos: assert property (p_pos) else $error("positive half drive wrong");
	property p_neg; br && !LINE_PHASE_SENSE_INPUT |=>
		SECOND_BOOST_TRANSISTOR == $past(PWM_DRIVE) && FIRST_BOOST_TRANSISTOR; endproperty
	a_neg: assert property (p_neg) else $error("negative half drive wrong");
	property p_both; BRIDGELESS_EN && (SOFT_START || !LINE_PHASE_OK) |=>
		{FIRST_BOOST_TRANSISTOR, SECOND_BOOST_TRANSISTOR} == {2{$past(PWM_DRIVE)}}; endproperty
	a_both: assert property (p_both) else $error("both switches not driven");
	property p_soft; SOFT_START ##1 SOFT_START |-> !SYNC_LOCKED; endproperty
	a_soft: assert property (p_soft) else $error("locked during soft start");
	property p_llf; $rose(LL_FREQ_ACTIVE) |-> $past(ev) || $past(ev, 2); endproperty
	a_llf: assert property (p_llf) else $error("light load set off line cycle");
	property p_shed; $fell(SECOND_PWM_ENABLE) |-> $past(ev) || $past(ev, 2); endproperty
	a_shed: assert property (p_shed) else $error("shed off line cycle");
	property p_filt; $rose(LL_FILTER_SEL) |-> $past(ev) || $past(ev, 2); endproperty
	a_filt: assert property (p_filt) else $error("filter set off line cycle");
	c_lock: cover property ($rose(SYNC_LOCKED));
	c_filt: cover property ($rose(LL_FILTER_SEL));
	c_shed: cover property ($fell(SECOND_PWM_ENABLE));
endmodule : pwa_top_chk
bind pwa_top pwa_top_chk #(.PER_W(PER_W)) i_pwa_top_chk (.*);

// file: verif/pwa_sync_src.sv
`timescale 1ns/100ps
module pwa_sync_src (
	// clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [11:0] per,
	// timing output
	output logic sync_out
);
	logic [11:0] cnt_r;
	// sibling timing source, low while stopped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 12'h000;
			sync_out <= 1'b0;
		end else if (!run) begin
			cnt_r <= 12'h000;
			sync_out <= 1'b0;
		end else begin
			cnt_r <= (cnt_r >= per - 12'h001) ? 12'h000 : cnt_r + 12'h001;
			sync_out <= (cnt_r < (per >> 1));
		end
	end
endmodule : pwa_sync_src

// file: verif/test_pwa_top.sv
`timescale 1ns/100ps
module test_pwa_top;
	// ----------------------------------------
	// signals, design and partner
	// ----------------------------------------
	logic CLK_SYS, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, SOFT_START, LINE_CYCLE;
	logic [19:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA;
	logic [3:0] AVS_BYTEENABLE;
	logic [7:0] VRMS_AVG, PIN_AVG, VLINE_RECT, VOUT_SETPOINT, v;
	logic [11:0] SW_PERIOD, src_per;
	logic SYNC_IN, PWM_CYCLE_START, SYNC_LOCKED, LL_FREQ_ACTIVE, LL_FILTER_SEL, FEEDFWD_EN;
	logic SECOND_PWM_ENABLE, BRIDGELESS_EN, PWM_DRIVE, LINE_PHASE_SENSE_INPUT, LINE_PHASE_OK;
	logic FIRST_BOOST_TRANSISTOR, SECOND_BOOST_TRANSISTOR, src_run;
	logic [7:0] lo[16] = '{8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h32, 8'h44, 8'h45, 8'h46, 8'h47,
		8'h48, 8'h49, 8'h4a, 8'h4c, 8'h4d, 8'h4e, 8'h4f};
	logic [15:0] cfg[19] = '{16'h1b78, 16'h1c96, 16'h1d00, 16'h1e00, 16'h3240, 16'h4420,
		16'h4560, 16'h4680, 16'h47a0, 16'h48b0, 16'h49d0, 16'h4ae0, 16'h4c00, 16'h4d10,
		16'h4e10, 16'h6064, 16'h6250, 16'h6390, 16'h64c0};
	logic [23:0] sp[9] = '{24'h301080, 24'h3070a0, 24'h304090, 24'ha010b0, 24'ha070d0,
		24'ha040c0, 24'hf040e0, 24'hbc10e0, 24'ha010b0};
	logic [31:0] exp_q[$];
	int n_errors, cmp_count, n;
	pwa_top i_pwa_top (.*);
	pwa_sync_src i_pwa_sync_src (.clk(CLK_SYS), .rst(SYS_RST), .run(src_run), .per(src_per),
		.sync_out(SYNC_IN));
	initial begin
		CLK_SYS = 1'b0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	// ----------------------------------------
	// tasks and read monitor
	// ----------------------------------------
	task automatic give_verdict();
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang(input string m);
		n_errors++;
		$display("[ERR] %0t timeout %s", $time, m);
		give_verdict();
	endtask : hang
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
		input logic [3:0] be);
		int i;
		@(posedge CLK_SYS);
		AVS_ADDRESS <= {10'h0fe, a, 2'b00};
		AVS_READ <= !w;
		AVS_WRITE <= w;
		AVS_WRITEDATA <= {24'($urandom), d};
		AVS_BYTEENABLE <= be;
		i = 0;
		do begin
			@(posedge CLK_SYS);
			i++;
		end while (AVS_WAITREQUEST !== 1'b0 && i < 32);
		if (i >= 32) hang("bus");
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d, 4'hf);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		bus(a, 1'b0, 8'h00, 4'hf);
	endtask : rd
	task automatic pulse(input int k);
		repeat (k) begin
			@(posedge CLK_SYS);
			LINE_CYCLE <= 1'b1;
			@(posedge CLK_SYS);
			LINE_CYCLE <= 1'b0;
			repeat (4) @(posedge CLK_SYS);
		end
	endtask : pulse
	task automatic per_meas(output int c);
		int i;
		i = 0;
		do begin
			@(negedge CLK_SYS);
			i++;
		end while (PWM_CYCLE_START !== 1'b1 && i < 2000);
		c = 0;
		do begin
			@(negedge CLK_SYS);
			c++;
		end while (PWM_CYCLE_START !== 1'b1 && c < 2000);
		if (c >= 2000) hang("cycle start");
		@(posedge CLK_SYS);
	endtask : per_meas
	task automatic wait_lock(output int c);
		c = 0;
		while (SYNC_LOCKED !== 1'b1) begin
			@(negedge CLK_SYS);
			c++;
			if (c > 20000) hang("lock");
		end
		@(posedge CLK_SYS);
	endtask : wait_lock
	always @(posedge CLK_SYS) begin
		if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
			if (exp_q.size() == 0) hang("read note");
			else chk(AVS_READDATA, exp_q.pop_front());
		end
	end
	initial begin
		repeat (90000) @(posedge CLK_SYS);
		hang("run");
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(8));
		{SYS_RST, AVS_READ, AVS_WRITE, SOFT_START, LINE_CYCLE, BRIDGELESS_EN} = 6'h20;
		{PWM_DRIVE, LINE_PHASE_SENSE_INPUT, LINE_PHASE_OK, src_run} = 4'h0;
		{AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} = 56'h0;
		{VRMS_AVG, PIN_AVG, VLINE_RECT} = 24'h000000;
		src_per = 12'h190;
		repeat (8) @(posedge CLK_SYS);
		SYS_RST <= 1'b0;
		foreach (lo[i]) rd(lo[i], lo[i] == 8'h1b ? pwa_pkg::RST_MAX_PER :
			lo[i] == 8'h1c ? pwa_pkg::RST_LL_FREQ : pwa_pkg::RST_ZERO);
		rd(8'h60, pwa_pkg::RST_NOM_PER);
		wr(8'h1f, 8'hff);
		rd(8'h1f, 8'h00);
		foreach (lo[i]) begin
			v = 8'($urandom);
			wr(lo[i], v);
			rd(lo[i], v);
		end
		foreach (cfg[i]) wr(cfg[i][15:8], cfg[i][7:0]);
		bus(8'h1d, 1'b1, 8'h5a, 4'he);
		rd(8'h1d, 8'h00);
		wr(8'h4f, 8'h78);
		PIN_AVG <= 8'($urandom_range(8'h00, 8'h3f));
		repeat (20) @(posedge CLK_SYS);
		chk({FEEDFWD_EN, LL_FREQ_ACTIVE}, 2'b10);
		pulse(1);
		chk({LL_FREQ_ACTIVE, SECOND_PWM_ENABLE, LL_FILTER_SEL}, 3'b100);
		pulse(2);
		chk(LL_FILTER_SEL, 1'b0);
		pulse(2);
		chk(LL_FILTER_SEL, 1'b1);
		PIN_AVG <= 8'($urandom_range(8'h41, 8'h50));
		pulse(1);
		chk({LL_FREQ_ACTIVE, SECOND_PWM_ENABLE, LL_FILTER_SEL}, 3'b101);
		rd(8'h65, 8'h18);
		PIN_AVG <= 8'($urandom_range(8'h51, 8'hff));
		pulse(1);
		chk({LL_FREQ_ACTIVE, SECOND_PWM_ENABLE, LL_FILTER_SEL}, 3'b010);
		wr(8'h4f, 8'h04);
		@(posedge CLK_SYS);
		chk(FEEDFWD_EN, 1'b0);
		foreach (sp[i]) begin
			VRMS_AVG <= sp[i][23:16];
			PIN_AVG <= sp[i][15:8];
			pulse(1);
			n = 0;
			while (VOUT_SETPOINT !== sp[i][7:0] && n < 16) begin
				@(posedge CLK_SYS);
				n++;
			end
			chk(VOUT_SETPOINT, sp[i][7:0]);
		end
		BRIDGELESS_EN <= 1'b1;
		repeat (400) begin
			@(posedge CLK_SYS);
			PWM_DRIVE <= 1'($urandom);
			LINE_PHASE_SENSE_INPUT <= 1'($urandom);
			LINE_PHASE_OK <= ($urandom_range(0, 3) != 0);
			SOFT_START <= ($urandom_range(0, 7) == 0);
		end
		@(posedge CLK_SYS);
		SOFT_START <= 1'b0;
		for (int d = 0; d < 4; d++) begin
			wr(8'h4f, 8'h00);
			wr(8'h1e, 8'(d));
			src_per <= 12'(32'h1a4 / (d + 1));
			src_run <= 1'b1;
			wr(8'h4f, 8'h02);
			wait_lock(n);
			chk(n >= 32'hb7c, 1'b1);
			per_meas(n);
			chk(n, 32'h1a4);
		end
		SOFT_START <= 1'b1;
		per_meas(n);
		per_meas(n);
		chk(n, 32'h190);
		SOFT_START <= 1'b0;
		wait_lock(n);
		src_run <= 1'b0;
		repeat (4) per_meas(n);
		chk({SYNC_LOCKED, n[30:0]}, {1'b0, 31'h1e0});
		chk(SW_PERIOD, 12'h1e0);
		wr(8'h1e, 8'h00);
		src_per <= 12'h12c;
		src_run <= 1'b1;
		n = 0;
		repeat (5000) begin
			@(posedge CLK_SYS);
			n += (SYNC_LOCKED === 1'b1);
		end
		chk(n, 32'h0);
		src_run <= 1'b0;
		wr(8'h4f, 8'h01);
		for (int k = 0; k < 2; k++) begin
			VLINE_RECT <= k ? 8'hff : 8'h00;
			per_meas(n);
			per_meas(n);
			chk(k ? n >= 32'h1c0 : n <= 32'h160, 1'b1);
		end
		repeat (8) begin
			VLINE_RECT <= 8'($urandom);
			per_meas(n);
			chk(n >= 32'h15e && n <= 32'h1c2, 1'b1);
		end
		give_verdict();
	end
endmodule : test_pwa_top
